// >>> pkg/fof_pkg.sv
// Package with timing counts, mode codes and pin levels for the fail output block.
package fof_pkg;

	// Clock rate in kHz (200 MHz).
	localparam int unsigned FOF_CLK_KHZ = 200000;

	// Blink period: 1.25 Hz is 800 ms; dimming period: 100 Hz is 10 ms.
	localparam int unsigned FOF_BLINK_PERIOD_MS = 800;
	localparam int unsigned FOF_DIM_PERIOD_MS = 10;
	localparam int unsigned FOF_BLINK_DUTY_PCT = 50;
	localparam int unsigned FOF_DIM_DUTY_PCT = 20;

	// Fail-safe input window, longest, in us; filter time, longest, in ns.
	localparam int unsigned FOF_FSI_WINDOW_US = 240;
	localparam int unsigned FOF_FSI_FILTER_NS = 1500;
	// Test-mode filter time, typical, in us.
	localparam int unsigned FOF_TEST_FILTER_US = 16;

	// Derived cycle counts; longest times round down.
	localparam int unsigned FOF_BLINK_CYC = FOF_BLINK_PERIOD_MS * (FOF_CLK_KHZ);
	localparam int unsigned FOF_BLINK_LOW_CYC = FOF_BLINK_CYC / 100 * FOF_BLINK_DUTY_PCT;
	localparam int unsigned FOF_DIM_CYC = FOF_DIM_PERIOD_MS * FOF_CLK_KHZ;
	localparam int unsigned FOF_DIM_LOW_CYC = FOF_DIM_CYC / 100 * FOF_DIM_DUTY_PCT;
	localparam int unsigned FOF_FSI_WINDOW_CYC = FOF_FSI_WINDOW_US * FOF_CLK_KHZ / 1000;
	localparam int unsigned FOF_FSI_FILTER_CYC = FOF_FSI_FILTER_NS * FOF_CLK_KHZ / 1000000;
	localparam int unsigned FOF_TEST_FILTER_CYC = FOF_TEST_FILTER_US * FOF_CLK_KHZ / 1000;

	// Operating modes of the chip as seen by this block.
	typedef enum logic [2:0] {
		FOF_MODE_INIT = 3'h0,
		FOF_MODE_NORMAL = 3'h1,
		FOF_MODE_STOP = 3'h2,
		FOF_MODE_SLEEP = 3'h3,
		FOF_MODE_RESTART = 3'h4,
		FOF_MODE_FAILSAFE = 3'h5
	} fof_mode_t;

	// Fail-safe input supervision states.
	typedef enum logic [1:0] {
		FOF_FSI_OFF = 2'h0,
		FOF_FSI_WAIT = 2'h1,
		FOF_FSI_FAILED = 2'h2
	} fof_fsi_st_t;

	// Reset values.
	localparam logic FOF_FSI_DIS_RST = 1'b0;
	localparam logic FOF_TEST_RST = 1'b1;

endpackage

// >>> logic/fof_fail_outputs.sv
// Failure logic: three open-drain fail outputs and the fail-safe input monitor.
`timescale 1ns/10ps
module fof_fail_outputs
	import fof_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [2:0] opMode,
	input wire logic watchdogResetEvt,
	input wire logic watchdogTriggerOk,
	input wire logic watchdogFailCountSelect,
	input wire logic thermalShutdownLevel2,
	input wire logic bucksupplyRailShort,
	input wire logic resetOutputDriven,
	input wire logic resetOutputSense,
	input wire logic failsafeInputDisable,
	input wire logic failActiveClear,
	input wire logic failsafeFailClear,
	input wire logic failStaticIn,
	input wire logic failsafeInputPin,
	input wire logic failDimIn,
	output logic failStaticOut,
	output logic failStaticOe,
	output logic failBlinkOut,
	output logic failBlinkOe,
	output logic failDimOut,
	output logic failDimOe,
	output logic failStaticPullup,
	output logic failBlinkPullup,
	output logic failDimPullup,
	output logic failOutputActiveFlag,
	output logic failsafeInputFailFlag,
	output logic [1:0] watchdogFailFlag,
	output logic resetClampFlag,
	output logic testModeSelect
);

	typedef struct packed {
		logic active;
		logic fsiFail;
		logic [1:0] wdFail;
		logic clamp;
		logic [28:0] blinkCnt;
		logic [21:0] dimCnt;
		logic [15:0] winCnt;
		fof_fsi_st_t fsiSt;
		logic fsiFilt;
		logic fsiPrev;
		logic [8:0] fsiFltCnt;
		logic freshEdge;
		logic testLvl;
		logic [12:0] testCnt;
		logic outStatic;
		logic outBlink;
		logic outDim;
	} fof_state_t;

	fof_state_t st_ff;
	fof_state_t nxt_st;

	logic normalMode;
	logic wdCause;
	logic anyCause;
	logic fsiRise;

	// Causes are combined here; the input failure only drives two outputs.
	always_comb begin
		normalMode = (opMode == 3'(FOF_MODE_NORMAL));
		wdCause = watchdogFailCountSelect ? st_ff.wdFail[1] : st_ff.wdFail[0];
		anyCause = wdCause | thermalShutdownLevel2 | bucksupplyRailShort | st_ff.clamp;
		fsiRise = st_ff.fsiFilt & ~st_ff.fsiPrev;
	end

	// All next-state logic sits in this one process.
	always_comb begin
		nxt_st = st_ff;
		// Watchdog failures count up to two; a good trigger clears them.
		if (watchdogResetEvt) begin
			nxt_st.wdFail = st_ff.wdFail[0] ? 2'h3 : 2'h1;
		end else if (watchdogTriggerOk) begin
			nxt_st.wdFail = 2'h0;
		end
		// Clamp is caught while reset is driven but the pin reads high; set wins over clear.
		if (resetOutputDriven && resetOutputSense) begin
			nxt_st.clamp = 1'b1;
		end else if (failActiveClear && !resetOutputDriven) begin
			nxt_st.clamp = 1'b0;
		end
		// Activation is sticky; the clear is honoured only with no cause left.
		if (anyCause) begin
			nxt_st.active = 1'b1;
		end else if (failActiveClear && st_ff.wdFail == 2'h0) begin
			nxt_st.active = 1'b0;
		end
		// Deglitch: the filtered level follows only after a stable run.
		if (failsafeInputPin == st_ff.fsiFilt) begin
			nxt_st.fsiFltCnt = 9'h000;
		end else if (st_ff.fsiFltCnt >= 9'(FOF_FSI_FILTER_CYC - 1)) begin
			nxt_st.fsiFilt = failsafeInputPin;
			nxt_st.fsiFltCnt = 9'h000;
		end else begin
			nxt_st.fsiFltCnt = st_ff.fsiFltCnt + 9'h001;
		end
		nxt_st.fsiPrev = st_ff.fsiFilt;
		if (fsiRise) begin
			nxt_st.freshEdge = 1'b1;
		end
		// Window supervision; only mode and disable bit gate it, no reset or interrupt.
		case (st_ff.fsiSt)
			FOF_FSI_OFF: begin
				nxt_st.winCnt = 16'h0000;
				if (normalMode && !failsafeInputDisable) begin
					nxt_st.fsiSt = FOF_FSI_WAIT;
				end
			end
			FOF_FSI_WAIT: begin
				if (!normalMode || failsafeInputDisable) begin
					nxt_st.fsiSt = FOF_FSI_OFF;
				end else if (fsiRise) begin
					nxt_st.winCnt = 16'h0000;
				end else if (st_ff.winCnt >= 16'(FOF_FSI_WINDOW_CYC - 1)) begin
					nxt_st.fsiFail = 1'b1;
					nxt_st.freshEdge = 1'b0;
					nxt_st.winCnt = 16'h0000;
				end else begin
					nxt_st.winCnt = st_ff.winCnt + 16'h0001;
				end
			end
			default: begin
				nxt_st.fsiSt = FOF_FSI_OFF;
			end
		endcase
		// The input flag takes a clear only after a new edge; a fresh timeout wins.
		if (failsafeFailClear && st_ff.freshEdge && nxt_st.fsiFail == st_ff.fsiFail) begin
			nxt_st.fsiFail = 1'b0;
		end
		// The blink counter restarts at activation and the dim counter when the first failure of either kind appears, so the low phase comes first.
		if (!nxt_st.active) begin
			nxt_st.blinkCnt = 29'h00000000;
		end else if (st_ff.blinkCnt >= 29'(FOF_BLINK_CYC - 1)) begin
			nxt_st.blinkCnt = 29'h00000000;
		end else begin
			nxt_st.blinkCnt = st_ff.blinkCnt + 29'h00000001;
		end
		if (!(nxt_st.active || nxt_st.fsiFail)) begin
			nxt_st.dimCnt = 22'h000000;
		end else if (st_ff.dimCnt >= 22'(FOF_DIM_CYC - 1) || !(st_ff.active || st_ff.fsiFail)) begin
			nxt_st.dimCnt = 22'h000000;
		end else begin
			nxt_st.dimCnt = st_ff.dimCnt + 22'h000001;
		end
		// Output drive, one cycle behind the counters so outputs come from flops.
		nxt_st.outStatic = st_ff.active | st_ff.fsiFail;
		nxt_st.outBlink = st_ff.active && (st_ff.blinkCnt < 29'(FOF_BLINK_LOW_CYC));
		nxt_st.outDim = (st_ff.active | st_ff.fsiFail)
			&& (st_ff.dimCnt < 22'(FOF_DIM_LOW_CYC));
		// Test level on the dim pin is accepted after a steady run.
		if (failDimIn == st_ff.testLvl) begin
			nxt_st.testCnt = 13'h0000;
		end else if (st_ff.testCnt >= 13'(FOF_TEST_FILTER_CYC - 1)) begin
			nxt_st.testLvl = failDimIn;
			nxt_st.testCnt = 13'h0000;
		end else begin
			nxt_st.testCnt = st_ff.testCnt + 13'h0001;
		end
	end

	// State register; reset gives idle outputs and monitoring enabled.
	always_ff @(posedge clk) begin
		if (srst) begin
			st_ff <= '0;
			st_ff.fsiFilt <= 1'b1;
			st_ff.fsiPrev <= 1'b1;
			st_ff.testLvl <= FOF_TEST_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Open-drain: drive low while the enable is high.
	always_comb begin
		failStaticOut = 1'b0;
		failBlinkOut = 1'b0;
		failDimOut = 1'b0;
		failStaticOe = st_ff.outStatic;
		failBlinkOe = st_ff.outBlink;
		failDimOe = st_ff.outDim;
		failOutputActiveFlag = st_ff.active;
		failsafeInputFailFlag = st_ff.fsiFail;
		watchdogFailFlag = st_ff.wdFail;
		resetClampFlag = st_ff.clamp;
		testModeSelect = st_ff.testLvl;
		// Pull-ups follow the mode; the blink pin's one yields to the disable bit.
		failStaticPullup = (opMode == 3'(FOF_MODE_INIT)) || normalMode;
		failBlinkPullup = ((opMode == 3'(FOF_MODE_INIT)) || normalMode) && !failsafeInputDisable;
		failDimPullup = (opMode == 3'(FOF_MODE_INIT));
	end

	a_static_follows: assert property (@(posedge clk) disable iff (srst)
		(st_ff.active || st_ff.fsiFail) |=> failStaticOe)
		else $error("Static output not driven while failure active.");

	a_cause_sets_flag: assert property (@(posedge clk) disable iff (srst)
		(thermalShutdownLevel2 || bucksupplyRailShort) |=> failOutputActiveFlag)
		else $error("Active flag missing after failure cause.");

	a_clear_blocked: assert property (@(posedge clk) disable iff (srst)
		(failOutputActiveFlag && watchdogFailFlag != 2'h0) |=> failOutputActiveFlag)
		else $error("Active flag cleared with watchdog flag set.");

	a_cause_holds: assert property (@(posedge clk) disable iff (srst)
		(failOutputActiveFlag && thermalShutdownLevel2) |=> failOutputActiveFlag)
		else $error("Active flag dropped while cause present.");

	a_clamp_set: assert property (@(posedge clk) disable iff (srst)
		(resetOutputDriven && resetOutputSense) |=> resetClampFlag)
		else $error("Reset clamp not flagged.");

	a_wd_second: assert property (@(posedge clk) disable iff (srst)
		($rose(watchdogFailFlag[0]) && watchdogFailCountSelect && !thermalShutdownLevel2
		&& !bucksupplyRailShort && !resetClampFlag && !failOutputActiveFlag)
		|=> !failOutputActiveFlag)
		else $error("Activated on first watchdog failure in second mode.");

	a_fsi_offmode: assert property (@(posedge clk) disable iff (srst)
		(!normalMode && !failsafeInputFailFlag) |=> !$rose(failsafeInputFailFlag))
		else $error("Input failure flagged outside normal mode.");

	a_fsi_noclear: assert property (@(posedge clk) disable iff (srst)
		(failsafeInputFailFlag && !st_ff.freshEdge) |=> failsafeInputFailFlag)
		else $error("Input flag cleared without a fresh edge.");

	a_blink_lowfirst: assert property (@(posedge clk) disable iff (srst)
		$rose(failOutputActiveFlag) |=> failBlinkOe [*8])
		else $error("Blink did not start low.");

	a_pullup_dim: assert property (@(posedge clk) disable iff (srst)
		failDimPullup |-> (opMode == 3'(FOF_MODE_INIT)))
		else $error("Dim pull-up outside init mode.");

	// A clamp that is flagged keeps the outputs on, like any other cause.
	a_clamp_activates: assert property (@(posedge clk) disable iff (srst)
		resetClampFlag |=> failOutputActiveFlag)
		else $error("Clamp flag did not activate the outputs.");

	// With the select bit low the first watchdog failure is enough.
	a_wd_first: assert property (@(posedge clk) disable iff (srst)
		(!watchdogFailCountSelect && watchdogFailFlag[0]) |=> failOutputActiveFlag)
		else $error("First watchdog failure did not activate.");

	// With the select bit high the second watchdog failure activates.
	a_wd_second_act: assert property (@(posedge clk) disable iff (srst)
		(watchdogFailCountSelect && watchdogFailFlag[1]) |=> failOutputActiveFlag)
		else $error("Second watchdog failure did not activate.");

	// A clear with no cause and no watchdog flag left must be honoured.
	a_clear_works: assert property (@(posedge clk) disable iff (srst)
		(failActiveClear && !thermalShutdownLevel2 && !bucksupplyRailShort
		&& !resetClampFlag && watchdogFailFlag == 2'h0) |=> !failOutputActiveFlag)
		else $error("Active flag not cleared although allowed.");

	// Open-drain data levels never drive high, so the pins can only sink.
	a_out_low: assert property (@(posedge clk) disable iff (srst)
		!failStaticOut && !failBlinkOut && !failDimOut)
		else $error("Fail output data not low.");

	// The blink output stays released while the active flag is clear.
	a_blink_idle: assert property (@(posedge clk) disable iff (srst)
		!failOutputActiveFlag |=> !failBlinkOe)
		else $error("Blink output driven while inactive.");

	// The dim output stays released with no failure of either kind.
	a_dim_idle: assert property (@(posedge clk) disable iff (srst)
		(!failOutputActiveFlag && !failsafeInputFailFlag) |=> !failDimOe)
		else $error("Dim output driven with no failure.");

	// Activation from a quiet state: all three switches come on together.
	sequence s_quiet_rise;
		$rose(failOutputActiveFlag) && !$past(failsafeInputFailFlag);
	endsequence

	sequence s_all_on;
		failStaticOe && failBlinkOe && failDimOe;
	endsequence

	a_all_on: assert property (@(posedge clk) disable iff (srst)
		s_quiet_rise |=> s_all_on)
		else $error("Outputs not switched on together.");

	// An input failure from a quiet state starts the dim low phase at once.
	a_dim_lowfirst: assert property (@(posedge clk) disable iff (srst)
		($rose(failsafeInputFailFlag) && !failOutputActiveFlag && !$past(failOutputActiveFlag))
		|=> failDimOe [*8])
		else $error("Dim did not start low on input failure.");

	// An input failure alone never sets the active flag.
	a_fsi_not_active: assert property (@(posedge clk) disable iff (srst)
		(!failOutputActiveFlag && !thermalShutdownLevel2 && !bucksupplyRailShort
		&& !resetClampFlag && watchdogFailFlag == 2'h0) |=> !failOutputActiveFlag)
		else $error("Active flag set without a listed cause.");

	// An input failure leaves the blink switch off.
	a_fsi_blink_off: assert property (@(posedge clk) disable iff (srst)
		(failsafeInputFailFlag && !failOutputActiveFlag) |=> !failBlinkOe)
		else $error("Blink driven by input failure.");

	// The disable bit stops any new input failure.
	a_fsi_disabled: assert property (@(posedge clk) disable iff (srst)
		(failsafeInputDisable && !failsafeInputFailFlag) |=> !failsafeInputFailFlag)
		else $error("Input failure flagged while disabled.");

	// The window counter never runs past the longest window.
	a_window_bound: assert property (@(posedge clk) disable iff (srst)
		st_ff.winCnt < 16'(FOF_FSI_WINDOW_CYC))
		else $error("Window counter past its limit.");

	// The filtered input only moves while the raw pin disagrees with it.
	a_fsi_filter: assert property (@(posedge clk) disable iff (srst)
		(failsafeInputPin == st_ff.fsiFilt) |=> $stable(st_ff.fsiFilt))
		else $error("Filtered input moved without a pin change.");

	// The test level only moves while the pin disagrees with it.
	a_test_steady: assert property (@(posedge clk) disable iff (srst)
		(failDimIn == testModeSelect) |=> $stable(testModeSelect))
		else $error("Test level moved without a pin change.");

	// Each watchdog reset leaves at least one failure recorded.
	a_wd_counts: assert property (@(posedge clk) disable iff (srst)
		watchdogResetEvt |=> watchdogFailFlag[0])
		else $error("Watchdog failure not recorded.");

	// A good trigger alone wipes the watchdog record.
	a_wd_clears: assert property (@(posedge clk) disable iff (srst)
		(watchdogTriggerOk && !watchdogResetEvt) |=> watchdogFailFlag == 2'h0)
		else $error("Watchdog flag not cleared by good trigger.");

	// The clamp flag is sticky until software clears it.
	a_clamp_holds: assert property (@(posedge clk) disable iff (srst)
		(resetClampFlag && !failActiveClear) |=> resetClampFlag)
		else $error("Clamp flag dropped without a clear.");

	// The static pull-up follows init and normal mode.
	a_pullup_static: assert property (@(posedge clk) disable iff (srst)
		failStaticPullup == ((opMode == 3'(FOF_MODE_INIT)) || normalMode))
		else $error("Static pull-up wrong for mode.");

	// The blink pull-up yields to the disable bit.
	a_pullup_blink: assert property (@(posedge clk) disable iff (srst)
		failBlinkPullup |-> !failsafeInputDisable)
		else $error("Blink pull-up on while input disabled.");

endmodule

// >>> verification/fof_partner.sv
// Model of the indicator loads and the supervising microcontroller on the fail pins.
`timescale 1ns/10ps
module fof_partner (
	input wire logic clk,
	input wire logic failStaticOe,
	input wire logic failBlinkOe,
	input wire logic failDimOe,
	input wire logic mcuRun,
	input wire logic mcuLevel,
	input wire logic testLow,
	output logic failStaticIn,
	output logic failsafeInputPin,
	output logic failDimIn
);
	logic [11:0] divCnt = 12'h000;
	logic osc = 1'b0;
	// Square wave of 40 us period, so every window sees a rising edge.
	always @(posedge clk) begin
		divCnt <= (divCnt == 12'hF9F) ? 12'h000 : divCnt + 12'h001;
		if (divCnt == 12'hF9F) begin
			osc <= ~osc;
		end
	end
	// Loads pull the pins high; an active low-side switch always wins.
	assign failStaticIn = ~failStaticOe;
	assign failsafeInputPin = ~failBlinkOe & (mcuRun ? osc : mcuLevel);
	assign failDimIn = ~failDimOe & ~testLow;
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the fail outputs and the fail-safe input monitor.
`timescale 1ns/10ps
module testbench;
	import fof_pkg::*;
	logic clk, srst, watchdogResetEvt, watchdogTriggerOk, watchdogFailCountSelect;
	logic thermalShutdownLevel2, bucksupplyRailShort, resetOutputDriven, resetOutputSense;
	logic failsafeInputDisable, failActiveClear, failsafeFailClear, mcuRun, mcuLevel, testLow;
	logic [2:0] opMode;
	logic failStaticIn, failsafeInputPin, failDimIn, failStaticOe, failBlinkOe, failDimOe;
	logic failStaticPullup, failBlinkPullup, failDimPullup, failOutputActiveFlag;
	logic failsafeInputFailFlag, resetClampFlag, testModeSelect;
	logic [1:0] watchdogFailFlag;
	logic failStaticOut, failBlinkOut, failDimOut;
	int errorCnt, compares;
	fof_fail_outputs DUT (.clk, .srst, .opMode, .watchdogResetEvt, .watchdogTriggerOk,
		.watchdogFailCountSelect, .thermalShutdownLevel2, .bucksupplyRailShort,
		.resetOutputDriven, .resetOutputSense, .failsafeInputDisable, .failActiveClear,
		.failsafeFailClear, .failStaticIn, .failsafeInputPin, .failDimIn, .failStaticOut,
		.failStaticOe, .failBlinkOut, .failBlinkOe, .failDimOut, .failDimOe,
		.failStaticPullup, .failBlinkPullup, .failDimPullup, .failOutputActiveFlag,
		.failsafeInputFailFlag, .watchdogFailFlag, .resetClampFlag, .testModeSelect);
	fof_partner loads (.clk, .failStaticOe, .failBlinkOe, .failDimOe, .mcuRun, .mcuLevel,
		.testLow, .failStaticIn, .failsafeInputPin, .failDimIn);
	task automatic wrapUp();
		$display("Counts: %0d compares, %0d mismatches", compares, errorCnt);
		if (errorCnt == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [2:0] act, input logic [2:0] exp);
		compares++;
		if (act !== exp) begin
			errorCnt++;
			$display("[FAIL] t=%0t got %h exp %h", $time, act, exp);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask
	function automatic logic [2:0] oe();
		return {failStaticOe, failBlinkOe, failDimOe};
	endfunction
	// One-cycle strobe: 0 active clear, 1 input clear, 2 watchdog reset, 3 good trigger.
	task automatic pulse(input int k);
		w(1);
		failActiveClear <= (k == 0);
		failsafeFailClear <= (k == 1);
		watchdogResetEvt <= (k == 2);
		watchdogTriggerOk <= (k == 3);
		w(1);
		{failActiveClear, failsafeFailClear, watchdogResetEvt, watchdogTriggerOk} <= 4'h0;
		w(3);
		#1;
	endtask
	// Cause k (0 thermal, 1 rail short, 2 clamp) raised in mode m, then removed.
	task automatic t_cause(input int k, input logic [2:0] m);
		w(1);
		opMode <= m;
		thermalShutdownLevel2 <= (k == 0);
		bucksupplyRailShort <= (k == 1);
		resetOutputDriven <= (k == 2);
		resetOutputSense <= (k == 2);
		w(3);
		#1 chk({failOutputActiveFlag, resetClampFlag, 1'b0}, {1'b1, k == 2, 1'b0});
		w(100);
		#1 chk(oe(), 3'h7);
		chk({failStaticOut, failBlinkOut, failDimOut}, 3'h0);
		pulse(0);
		chk({2'b00, failOutputActiveFlag}, 3'h1);
		w(1);
		{thermalShutdownLevel2, bucksupplyRailShort, resetOutputDriven, resetOutputSense} <= 4'h0;
		w(3);
		#1 chk({2'b00, failOutputActiveFlag}, 3'h1);
		pulse(0);
		// A clamp is itself the cause: the first clear drops it, the second the flag.
		if (k == 2) begin
			chk({2'b00, failOutputActiveFlag}, 3'h1);
			pulse(0);
		end
		chk({1'b0, failOutputActiveFlag, resetClampFlag}, 3'h0);
		w(2);
		#1 chk(oe(), 3'h0);
	endtask
	// Watchdog failures counted against the select bit, cleared only after a good trigger.
	task automatic t_wd(input logic sel);
		w(1);
		opMode <= FOF_MODE_NORMAL;
		watchdogFailCountSelect <= sel;
		for (int i = 0; i <= sel; i++) begin
			pulse(2);
			chk({watchdogFailFlag, failOutputActiveFlag}, {i ? 2'b11 : 2'b01, i == sel});
		end
		pulse(0);
		chk({2'b00, failOutputActiveFlag}, 3'h1);
		pulse(3);
		pulse(0);
		chk({watchdogFailFlag, failOutputActiveFlag}, 3'h0);
		w(2);
		#1 chk(oe(), 3'h0);
	endtask
	task automatic t_pullup();
		for (int m = 0; m < 6; m++) begin
			for (int d = 0; d < 2; d++) begin
				w(1);
				opMode <= m[2:0];
				failsafeInputDisable <= d[0];
				w(1);
				#1 chk({failStaticPullup, failBlinkPullup, failDimPullup}, {m < 2, m < 2 && d == 0, m == 0});
			end
		end
	endtask
	// A short low on the dim pin is ignored; a long one is taken.
	task automatic t_test();
		w(1);
		testLow <= 1'b1;
		w(1000);
		testLow <= 1'b0;
		w(10);
		#1 chk({2'b00, testModeSelect}, 3'h1);
		w(1);
		testLow <= 1'b1;
		w(3300);
		#1 chk({2'b00, testModeSelect}, 3'h0);
		w(1);
		testLow <= 1'b0;
	endtask
	task automatic t_fsi();
		int i;
		w(1);
		opMode <= FOF_MODE_NORMAL;
		failsafeInputDisable <= 1'b0;
		w(20000);
		#1 chk({2'b00, failsafeInputFailFlag}, 3'h0);
		w(1);
		mcuRun <= 1'b0;
		mcuLevel <= 1'b0;
		for (i = 0; i < 50000 && failsafeInputFailFlag !== 1'b1; i++)
			w(1);
		chk({2'b00, i < 48400}, 3'h1);
		w(2);
		#1 chk(oe(), 3'h5);
		pulse(1);
		chk({2'b00, failsafeInputFailFlag}, 3'h1);
		// A 100-cycle high is shorter than the filter and must not count as an edge.
		w(1);
		mcuLevel <= 1'b1;
		w(100);
		mcuLevel <= 1'b0;
		pulse(1);
		chk({2'b00, failsafeInputFailFlag}, 3'h1);
		w(1);
		mcuLevel <= 1'b1;
		w(400);
		pulse(1);
		chk({2'b00, failsafeInputFailFlag}, 3'h0);
		w(2);
		#1 chk(oe(), 3'h0);
		w(1);
		mcuRun <= 1'b1;
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Long enough for the input window test plus all the short scenarios.
	initial begin
		w(90000);
		errorCnt++;
		wrapUp();
	end
	initial begin
		errorCnt = 0;
		compares = 0;
		srst = 1'b1;
		opMode = FOF_MODE_NORMAL;
		{watchdogResetEvt, watchdogTriggerOk, watchdogFailCountSelect} = 3'h0;
		{thermalShutdownLevel2, bucksupplyRailShort, resetOutputDriven, resetOutputSense} = 4'h0;
		{failsafeInputDisable, failActiveClear, failsafeFailClear} = 3'h0;
		{mcuRun, mcuLevel, testLow} = 3'h4;
		w(6);
		srst <= 1'b0;
		w(1);
		#1 chk({failOutputActiveFlag, failsafeInputFailFlag, resetClampFlag}, 3'h0);
		chk({watchdogFailFlag, testModeSelect}, 3'h1);
		t_cause(0, FOF_MODE_NORMAL);
		t_cause(1, FOF_MODE_FAILSAFE);
		t_cause(2, FOF_MODE_RESTART);
		t_wd(1'b0);
		t_wd(1'b1);
		t_pullup();
		t_test();
		t_fsi();
		wrapUp();
	end
endmodule
